//--- src/pid_limit_defines.svh
// Register offsets, reset values and timing counts of the PID limit and feedback-loss block.
`ifndef PID_LIMIT_DEFINES_SVH
`define PID_LIMIT_DEFINES_SVH
`define ADDR_W            12
`define REG_INT_CLAMP     12'h710
`define REG_D_SMOOTH      12'h711
`define REG_OUT_CLAMP     12'h712
`define REG_FB_READBACK   12'h713
`define REG_LOSS_TIME     12'h714
`define REG_LOSS_ACTION   12'h715
`define REG_LOSS_SPEED    12'h716
`define REG_IRQ_STATUS    12'h7f0
`define REG_IRQ_MASK      12'h7f1
`define REG_LOSS_STATE    12'h7f2
`define RST_PCT_100       16'h03e8
`define PCT_SCALE         32'd1000
`define FB_MAX            16'sh4e20
`define FB_MIN            -16'sh4e20
`define CLK_PERIOD_NS     50
`define EVAL_PERIOD_NS    1000000
`define EVAL_CYCLES       (`EVAL_PERIOD_NS / `CLK_PERIOD_NS)
`define EVAL_PERIOD_MS    1
`define DETECT_UNIT_MS    100
`define TICKS_PER_UNIT    (`DETECT_UNIT_MS / `EVAL_PERIOD_MS)
`define IRQ_WARN_BIT      0
`define IRQ_FAULT_BIT     1
`endif

//--- src/pid_limit_pkg.sv
// Types shared by the PID limit and feedback-loss block.
package pid_limit_pkg;
    typedef enum logic [1:0] {
        LOSS_IDLE   = 2'b00,
        LOSS_TIMING = 2'b01,
        LOSS_WARN   = 2'b11,
        LOSS_FAULT  = 2'b10
    } loss_state_t;

    typedef enum logic [2:0] {
        ACT_CONTINUE = 3'h0,
        ACT_RAMP     = 3'h1,
        ACT_COAST    = 3'h2,
        ACT_HOLD     = 3'h3,
        ACT_FALLBACK = 3'h4
    } loss_action_t;
endpackage

//--- src/pid_limit_feedback_loss.sv
// PID derivative filter, integral and output clamps, feedback readback and feedback-loss handling.
//
// Added by the designer: strobed register access.
`include "pid_limit_defines.svh"

module pid_limit_feedback_loss
    import pid_limit_pkg::*;
#(
    parameter int EVAL_CYCLES = `EVAL_CYCLES
) (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 nrst,
    // Register port
    input  wire logic [`ADDR_W-1:0]   addr,
    input  wire logic [15:0]          wdata,
    input  wire logic                 wr,
    input  wire logic                 rd,
    output logic      [15:0]          rdata,
    // PID unit side
    input  wire logic                 pid_active,
    input  wire logic signed [15:0]   error,
    input  wire logic        [15:0]   max_output_frequency,
    input  wire logic signed [15:0]   feedback_pct,
    output logic             [15:0]   freq_command,
    // Feedback source and loss
    input  wire logic                 fb_is_ai2_ma,
    input  wire logic                 fb_signal_low,
    input  wire logic                 fault_reset,
    output logic                      loss_warning,
    output logic                      loss_fault,
    output logic                      ramp_stop,
    output logic                      coast_stop,
    // Interrupt
    output logic                      irq
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0]        integral_clamp_percent, next_integral_clamp_percent;
    logic [15:0]        derivative_smoothing_time, next_derivative_smoothing_time;
    logic [15:0]        output_freq_clamp_percent, next_output_freq_clamp_percent;
    logic signed [15:0] feedback_value_readback, next_feedback_value_readback;
    logic [15:0]        loss_detect_time, next_loss_detect_time;
    logic [2:0]         loss_action_select, next_loss_action_select;
    logic [15:0]        loss_fallback_speed, next_loss_fallback_speed;
    logic [1:0]         irq_status, next_irq_status;
    logic [1:0]         irq_mask, next_irq_mask;
    logic [15:0]        next_rdata;
    logic [1:0]         events;
    loss_state_t        state, next_state;
    logic               fault_coast;

    always_comb begin
        next_integral_clamp_percent    = integral_clamp_percent;
        next_derivative_smoothing_time = derivative_smoothing_time;
        next_output_freq_clamp_percent = output_freq_clamp_percent;
        next_loss_detect_time          = loss_detect_time;
        next_loss_action_select        = loss_action_select;
        next_loss_fallback_speed       = loss_fallback_speed;
        next_irq_mask                  = irq_mask;
        next_irq_status                = irq_status;
        if (feedback_pct > `FB_MAX) begin
            next_feedback_value_readback = `FB_MAX;
        end else if (feedback_pct < `FB_MIN) begin
            next_feedback_value_readback = `FB_MIN;
        end else begin
            next_feedback_value_readback = feedback_pct;
        end
        if (wr) begin
            case (addr)
                `REG_INT_CLAMP:   next_integral_clamp_percent = wdata;
                `REG_D_SMOOTH:    next_derivative_smoothing_time = wdata;
                `REG_OUT_CLAMP:   next_output_freq_clamp_percent = wdata;
                `REG_LOSS_TIME:   next_loss_detect_time = wdata;
                `REG_LOSS_ACTION: next_loss_action_select = wdata[2:0];
                `REG_LOSS_SPEED:  next_loss_fallback_speed = wdata;
                `REG_IRQ_STATUS:  next_irq_status = irq_status & ~wdata[1:0];
                `REG_IRQ_MASK:    next_irq_mask = wdata[1:0];
                default:          next_irq_mask = irq_mask;
            endcase
        end
        // A new event wins over a clear in the same cycle.
        next_irq_status = next_irq_status | events;
        next_rdata = 16'h0000;
        if (rd) begin
            case (addr)
                `REG_INT_CLAMP:   next_rdata = integral_clamp_percent;
                `REG_D_SMOOTH:    next_rdata = derivative_smoothing_time;
                `REG_OUT_CLAMP:   next_rdata = output_freq_clamp_percent;
                `REG_FB_READBACK: next_rdata = feedback_value_readback;
                `REG_LOSS_TIME:   next_rdata = loss_detect_time;
                `REG_LOSS_ACTION: next_rdata = {13'h0000, loss_action_select};
                `REG_LOSS_SPEED:  next_rdata = loss_fallback_speed;
                `REG_IRQ_STATUS:  next_rdata = {14'h0000, irq_status};
                `REG_IRQ_MASK:    next_rdata = {14'h0000, irq_mask};
                `REG_LOSS_STATE:  next_rdata = {13'h0000, fault_coast, state};
                default:          next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            integral_clamp_percent    <= `RST_PCT_100;
            derivative_smoothing_time <= 16'h0000;
            output_freq_clamp_percent <= `RST_PCT_100;
            feedback_value_readback   <= 16'sh0000;
            loss_detect_time          <= 16'h0000;
            loss_action_select        <= 3'h0;
            loss_fallback_speed       <= 16'h0000;
            irq_status                <= 2'h0;
            irq_mask                  <= 2'h0;
            rdata                     <= 16'h0000;
        end else begin
            integral_clamp_percent    <= next_integral_clamp_percent;
            derivative_smoothing_time <= next_derivative_smoothing_time;
            output_freq_clamp_percent <= next_output_freq_clamp_percent;
            feedback_value_readback   <= next_feedback_value_readback;
            loss_detect_time          <= next_loss_detect_time;
            loss_action_select        <= next_loss_action_select;
            loss_fallback_speed       <= next_loss_fallback_speed;
            irq_status                <= next_irq_status;
            irq_mask                  <= next_irq_mask;
            rdata                     <= next_rdata;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ------------------------------------------------------------
    // Evaluation and detection time base
    // ------------------------------------------------------------
    logic [15:0] tick_cnt, next_tick_cnt;
    logic [7:0]  unit_cnt, next_unit_cnt;
    logic        eval_tick, unit_tick;

    always_comb begin
        eval_tick     = (tick_cnt == 16'(EVAL_CYCLES - 1));
        unit_tick     = eval_tick && (unit_cnt == 8'(`TICKS_PER_UNIT - 1));
        next_tick_cnt = eval_tick ? 16'h0000 : tick_cnt + 16'h0001;
        next_unit_cnt = unit_tick ? 8'h00 : (eval_tick ? unit_cnt + 8'h01 : unit_cnt);
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tick_cnt <= 16'h0000;
            unit_cnt <= 8'h00;
        end else begin
            tick_cnt <= next_tick_cnt;
            unit_cnt <= next_unit_cnt;
        end
    end

    // ------------------------------------------------------------
    // PID terms and clamps
    // ------------------------------------------------------------
    logic signed [15:0] prev_err, next_prev_err;
    logic signed [16:0] d_raw;
    logic signed [23:0] d_filt, next_d_filt;
    logic signed [23:0] integ, next_integ, integ_sum, total;
    logic [31:0]        prod_i, prod_o;
    logic [15:0]        ilim;
    logic [16:0]        olim;
    logic [2:0]         shift;
    logic [15:0]        pid_cmd, next_pid_cmd;

    always_comb begin
        prod_i = max_output_frequency * integral_clamp_percent;
        prod_o = max_output_frequency * output_freq_clamp_percent;
        ilim   = 16'(prod_i / `PCT_SCALE);
        olim   = 17'(prod_o / `PCT_SCALE);
        if (derivative_smoothing_time >= 16'd16) shift = 3'd5;
        else if (derivative_smoothing_time >= 16'd8) shift = 3'd4;
        else if (derivative_smoothing_time >= 16'd4) shift = 3'd3;
        else if (derivative_smoothing_time >= 16'd2) shift = 3'd2;
        else shift = 3'(derivative_smoothing_time);
        d_raw       = 17'(error) - 17'(prev_err);
        next_d_filt = d_filt + ((24'(d_raw) - d_filt) >>> shift);
        integ_sum = integ + 24'(error);
        if (integ_sum > $signed({8'h00, ilim})) begin
            next_integ = $signed({8'h00, ilim});
        end else if (integ_sum < -$signed({8'h00, ilim})) begin
            next_integ = -$signed({8'h00, ilim});
        end else begin
            next_integ = integ_sum;
        end
        total = 24'(error) + next_integ + next_d_filt;
        if (total < 24'sh000000) begin
            next_pid_cmd = 16'h0000;
        end else if (total > $signed({7'h00, olim})) begin
            next_pid_cmd = 16'(olim);
        end else begin
            next_pid_cmd = 16'(total);
        end
        next_prev_err = error;
        if (!pid_active) begin
            next_prev_err = 16'sh0000;
            next_d_filt   = 24'sh000000;
            next_integ    = 24'sh000000;
            next_pid_cmd  = 16'h0000;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prev_err <= 16'sh0000;
            d_filt   <= 24'sh000000;
            integ    <= 24'sh000000;
            pid_cmd  <= 16'h0000;
        end else if (eval_tick || !pid_active) begin
            prev_err <= next_prev_err;
            d_filt   <= next_d_filt;
            integ    <= next_integ;
            pid_cmd  <= next_pid_cmd;
        end
    end

    // ------------------------------------------------------------
    // Feedback-loss detection and action
    // ------------------------------------------------------------
    logic        qual;
    logic [15:0] det_cnt, next_det_cnt;
    logic [15:0] held_cmd, next_held_cmd;
    logic        next_fault_coast;
    logic [15:0] next_freq_command;

    always_comb begin
        qual             = fb_signal_low && fb_is_ai2_ma && (loss_detect_time != 16'h0000);
        next_state       = state;
        next_det_cnt     = det_cnt;
        next_held_cmd    = held_cmd;
        next_fault_coast = fault_coast;
        events           = 2'b00;
        case (state)
            LOSS_IDLE: begin
                next_det_cnt = 16'h0000;
                if (qual) next_state = LOSS_TIMING;
            end
            LOSS_TIMING: begin
                if (!qual) begin
                    next_state = LOSS_IDLE;
                end else if (det_cnt >= loss_detect_time) begin
                    events[`IRQ_WARN_BIT] = 1'b1;
                    next_held_cmd = pid_cmd;
                    if (loss_action_select == ACT_RAMP || loss_action_select == ACT_COAST) begin
                        next_state = LOSS_FAULT;
                        next_fault_coast = (loss_action_select == ACT_COAST);
                        events[`IRQ_FAULT_BIT] = 1'b1;
                    end else begin
                        next_state = LOSS_WARN;
                    end
                end else if (unit_tick) begin
                    next_det_cnt = det_cnt + 16'h0001;
                end
            end
            LOSS_WARN: begin
                if (!qual) next_state = LOSS_IDLE;
            end
            LOSS_FAULT: begin
                if (fault_reset) next_state = LOSS_IDLE;
                next_fault_coast = fault_coast && !fault_reset;
            end
            default: next_state = LOSS_IDLE;
        endcase
        next_freq_command = pid_cmd;
        if (next_state == LOSS_FAULT) begin
            next_freq_command = 16'h0000;
        end else if (next_state == LOSS_WARN && loss_action_select == ACT_HOLD) begin
            next_freq_command = next_held_cmd;
        end else if (next_state == LOSS_WARN && loss_action_select == ACT_FALLBACK) begin
            next_freq_command = loss_fallback_speed;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state        <= LOSS_IDLE;
            det_cnt      <= 16'h0000;
            held_cmd     <= 16'h0000;
            fault_coast  <= 1'b0;
            freq_command <= 16'h0000;
        end else begin
            state        <= next_state;
            det_cnt      <= next_det_cnt;
            held_cmd     <= next_held_cmd;
            fault_coast  <= next_fault_coast;
            freq_command <= next_freq_command;
        end
    end

    assign loss_warning = (state == LOSS_WARN) || (state == LOSS_FAULT);
    assign loss_fault   = (state == LOSS_FAULT);
    assign ramp_stop    = loss_fault && !fault_coast;
    assign coast_stop   = loss_fault && fault_coast;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_fault_entry;
        state == LOSS_TIMING ##1 state == LOSS_FAULT;
    endsequence

    a_deriv_zero: assert property (eval_tick && pid_active && shift == 3'd0 && error == prev_err
        |=> d_filt == 24'sh000000) else $error("derivative not zero");
    a_integ_clamp: assert property (eval_tick && pid_active |=> integ <= $signed({8'h00, $past(ilim)})
        && integ >= -$signed({8'h00, $past(ilim)})) else $error("integrator outside clamp");
    a_filter_bypass: assert property (eval_tick && pid_active && shift == 3'd0
        |=> d_filt == 24'($past(d_raw))) else $error("unsmoothed derivative wrong");
    a_out_clamp: assert property (eval_tick && pid_active
        |=> 17'(pid_cmd) <= $past(olim)) else $error("output above clamp");
    a_readback_range: assert property (feedback_value_readback <= `FB_MAX
        && feedback_value_readback >= `FB_MIN) else $error("readback out of range");
    a_warn_after_time: assert property ($rose(loss_warning) |-> $past(det_cnt) >= $past(loss_detect_time)
        && $past(qual)) else $error("warning too early");
    a_no_detect_zero: assert property (loss_detect_time == 16'h0000 && state == LOSS_IDLE
        |=> state == LOSS_IDLE) else $error("detection with zero time");
    a_src_gate: assert property (!fb_is_ai2_ma && state != LOSS_FAULT |=> !loss_warning)
        else $error("detection on wrong source");
    a_hold_last: assert property (state == LOSS_WARN && loss_action_select == ACT_HOLD && qual
        |=> freq_command == held_cmd) else $error("held frequency wrong");
    a_fault_stop: assert property (s_fault_entry |-> freq_command == 16'h0000
        && (ramp_stop ^ coast_stop)) else $error("fault stop wrong");
    a_fault_sticky: assert property (loss_fault && !fault_reset |=> loss_fault)
        else $error("fault left without reset");
    a_fallback_speed: assert property (state == LOSS_WARN && loss_action_select == ACT_FALLBACK && qual
        |=> freq_command == $past(loss_fallback_speed)) else $error("fallback speed wrong");

endmodule // pid_limit_feedback_loss

//--- sim/fb_transmitter_model.sv
// Behavioural 4-20 mA feedback transmitter as seen through the analog front end.
module fb_transmitter_model
    import pid_limit_pkg::*;
(
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               nrst,
    // Test control
    input  wire logic               loop_broken,
    input  wire logic signed [15:0] level_pct,
    // Front-end outputs
    output logic                    fb_signal_low,
    output logic signed [15:0]      feedback_pct
);
    timeunit 1ns;
    timeprecision 1ns;

    logic               next_fb_signal_low;
    logic signed [15:0] next_feedback_pct;

    // -----------------------------------------------------------------
    // Loop current
    // -----------------------------------------------------------------
    // An open loop carries no current, which reads below the 4 mA zero
    // point, so the scaled value goes negative rather than holding.
    always_comb begin
        next_fb_signal_low = loop_broken;
        next_feedback_pct  = loop_broken ? -16'sd2500 : level_pct;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            fb_signal_low <= 1'b0;
            feedback_pct  <= 16'sh0000;
        end else begin
            fb_signal_low <= next_fb_signal_low;
            feedback_pct  <= next_feedback_pct;
        end
    end
endmodule // fb_transmitter_model

//--- sim/pid_limit_feedback_loss_tb_top.sv
// Self-checking testbench of the PID limit and feedback-loss block.
`include "pid_limit_defines.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); end end

module pid_limit_feedback_loss_tb_top
    import pid_limit_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic               sys_clk, nrst, wr, rd, pid_active, fb_is_ai2_ma, fault_reset;
    logic [11:0]        addr;
    logic [15:0]        wdata, rdata, max_output_frequency, freq_command;
    logic signed [15:0] error, feedback_pct, level_pct;
    logic               fb_signal_low, loss_warning, loss_fault, ramp_stop, coast_stop, irq, loop_broken;
    int                 n_errors, total_checks, i;
    logic [11:0]        rst_addr [10] = '{12'h710, 12'h711, 12'h712, 12'h713, 12'h714, 12'h715, 12'h716,
                                          12'h7f0, 12'h7f1, 12'h7ff};
    logic [15:0]        rst_val  [10] = '{16'h03e8, 16'h0, 16'h03e8, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    logic [15:0]        lv       [3]  = '{16'h7530, 16'h8ad0, 16'h04d2};
    logic [15:0]        rb       [3]  = '{16'h4e20, 16'hb1e0, 16'h04d2};
    logic [15:0]        sm       [2]  = '{16'h0000, 16'h0010};
    logic [15:0]        dexp     [2]  = '{16'h1900, 16'h0ce4};
    logic [15:0]        cmd_exp  [5]  = '{16'h09c4, 16'h0000, 16'h0000, 16'h0834, 16'h04d2};
    logic [15:0]        st_exp   [5]  = '{16'h0003, 16'h0002, 16'h0006, 16'h0003, 16'h0003};

    pid_limit_feedback_loss #(.EVAL_CYCLES(20)) u_dut (
        .sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .pid_active(pid_active), .error(error), .max_output_frequency(max_output_frequency),
        .feedback_pct(feedback_pct), .freq_command(freq_command), .fb_is_ai2_ma(fb_is_ai2_ma),
        .fb_signal_low(fb_signal_low), .fault_reset(fault_reset), .loss_warning(loss_warning),
        .loss_fault(loss_fault), .ramp_stop(ramp_stop), .coast_stop(coast_stop), .irq(irq));

    fb_transmitter_model u_xmtr (
        .sys_clk(sys_clk), .nrst(nrst), .loop_broken(loop_broken), .level_pct(level_pct),
        .fb_signal_low(fb_signal_low), .feedback_pct(feedback_pct));

    always #25 sys_clk = ~sys_clk;

    // -----------------------------------------------------------------
    // Bus and helper tasks
    // -----------------------------------------------------------------
    task automatic final_report();
        if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic reg_write(input logic [11:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr    <= 1'b0;
    endtask

    task automatic check_reg(input logic [11:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd   <= 1'b0;
        #1;
        `CHK(rdata, exp)
    endtask

    // Waits on the warning or on the first command; a spent bound ends the run.
    task automatic wait_high(input bit on_cmd, input int bound);
        for (int k = 0; k < bound && (on_cmd ? freq_command === 16'h0 : loss_warning !== 1'b1); k++) begin
            @(posedge sys_clk);
            #1;
        end
        if (on_cmd ? freq_command === 16'h0 : loss_warning !== 1'b1) begin
            n_errors++;
            $display("ERROR %0t: wait timed out", $time);
            final_report();
        end
    endtask

    task automatic loss_run(input logic [2:0] code);
        logic flt;
        flt = (code == 3'h1 || code == 3'h2);
        reg_write(`REG_LOSS_ACTION, {13'h0, code});
        reg_write(`REG_IRQ_MASK, (code == 3'h0) ? 16'h0 : 16'h3);
        @(posedge sys_clk);
        loop_broken <= 1'b1;
        cyc(1900);
        #1;
        `CHK(loss_warning, 1'b0)
        wait_high(1'b0, 6300);
        @(posedge sys_clk);
        error <= 16'sh01f4;
        cyc(300);
        #1;
        `CHK(loss_fault, flt)
        `CHK(ramp_stop, code == 3'h1)
        `CHK(coast_stop, code == 3'h2)
        `CHK(freq_command, cmd_exp[code])
        `CHK(irq, code != 3'h0)
        check_reg(`REG_IRQ_STATUS, flt ? 16'h3 : 16'h1);
        check_reg(`REG_LOSS_STATE, st_exp[code]);
        @(posedge sys_clk);
        loop_broken <= 1'b0;
        error       <= 16'sh0064;
        cyc(20);
        #1;
        `CHK(loss_fault, flt)
        `CHK(loss_warning, flt)
        @(posedge sys_clk);
        fault_reset <= 1'b1;
        @(posedge sys_clk);
        fault_reset <= 1'b0;
        cyc(3);
        #1;
        `CHK(loss_fault, 1'b0)
        reg_write(`REG_IRQ_STATUS, 16'h3);
        check_reg(`REG_IRQ_STATUS, 16'h0);
        `CHK(irq, 1'b0)
    endtask

    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        sys_clk = 0; nrst = 0; addr = 0; wdata = 0; wr = 0; rd = 0; pid_active = 0; error = 0;
        max_output_frequency = 16'h2710; fb_is_ai2_ma = 1; fault_reset = 0; loop_broken = 0; level_pct = 0;
        n_errors = 0; total_checks = 0;
        cyc(4);
        nrst <= 1'b1;
        for (i = 0; i < 10; i++) check_reg(rst_addr[i], rst_val[i]);
        reg_write(12'h7ff, 16'hffff);
        reg_write(`REG_FB_READBACK, 16'h1234);
        check_reg(12'h7ff, 16'h0);
        for (i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            level_pct <= lv[i];
            cyc(4);
            check_reg(`REG_FB_READBACK, rb[i]);
        end
        // A zero integral clamp leaves the first command as error plus filtered step.
        for (i = 0; i < 2; i++) begin
            reg_write(`REG_D_SMOOTH, sm[i]);
            reg_write(`REG_INT_CLAMP, 16'h0);
            @(posedge sys_clk);
            error      <= 16'sh0c80;
            pid_active <= 1'b1;
            wait_high(1'b1, 100);
            `CHK(freq_command, dexp[i])
            @(posedge sys_clk);
            pid_active <= 1'b0;
            cyc(4);
            #1;
            `CHK(freq_command, 16'h0)
        end
        reg_write(`REG_INT_CLAMP, 16'h00c8);
        reg_write(`REG_D_SMOOTH, 16'h0);
        reg_write(`REG_OUT_CLAMP, 16'h044c);
        @(posedge sys_clk);
        error      <= 16'sh0064;
        pid_active <= 1'b1;
        cyc(800);
        #1;
        `CHK(freq_command, 16'h0834)
        reg_write(`REG_OUT_CLAMP, 16'h0096);
        cyc(100);
        #1;
        `CHK(freq_command, 16'h05dc)
        reg_write(`REG_OUT_CLAMP, 16'h044c);
        reg_write(`REG_LOSS_TIME, 16'h0);
        @(posedge sys_clk);
        loop_broken <= 1'b1;
        cyc(6500);
        #1;
        `CHK(loss_warning, 1'b0)
        @(posedge sys_clk);
        fb_is_ai2_ma <= 1'b0;
        reg_write(`REG_LOSS_TIME, 16'h2);
        cyc(6500);
        #1;
        `CHK(loss_warning, 1'b0)
        @(posedge sys_clk);
        loop_broken  <= 1'b0;
        fb_is_ai2_ma <= 1'b1;
        reg_write(`REG_LOSS_SPEED, 16'h04d2);
        cyc(10);
        for (i = 0; i < 5; i++) loss_run(i[2:0]);
        final_report();
    end
endmodule // pid_limit_feedback_loss_tb_top
